// >>> verilog/prmirc_top.sv
// port mac control with ingress rate limiting and frame filtering
//
// Decided for this implementation: the placing of the registers and the plain strobed port.
module prmirc_top
    import prmirc_pkg::*;
(
    input  logic         clk,          // core clock, 125 mhz
    input  logic         rst,          // async reset, high
    input  logic [7:0]   reg_addr,     // register address
    input  logic [7:0]   reg_wdata,    // register write data
    input  logic         reg_wr,       // write strobe
    input  logic         reg_rd,       // read strobe
    output logic [7:0]   reg_rdata,    // read data, cycle after rd
    input  logic         half_duplex,  // link runs half duplex
    input  logic         fc_adv,       // partner flow control agreed
    input  logic         fc_filter_en, // global fc frame filter
    input  logic         in_valid,     // frame descriptor valid
    input  prmirc_desc_s in_desc,      // frame descriptor
    output logic         in_ready,     // descriptor taken
    output logic         out_valid,    // forwarded frame valid
    output prmirc_fwd_s  out_data,     // forwarded frame
    input  logic         out_ready,    // fabric accepts
    output logic         bp_assert,    // half duplex back pressure
    output logic         pause_req     // full duplex pause request
);
    localparam int HOLD_CYC   = `PRMIRC_HOLD_CYC;
    localparam int REFILL_CYC = `PRMIRC_REFILL_CYC;

    // register state, staged and live limits, token buckets and timers
    logic [7:0]  mac1;
    logic [7:0]  rate;
    logic [7:0]  ownctl;
    logic [6:0]  stage [8];
    logic [6:0]  lim_act [8];
    logic [7:0]  drops;
    prmirc_bkt_t bkt [8];
    prmirc_bkt_t next_bkt [8];
    logic [6:0]  refill_cnt;
    logic        tick;
    logic [6:0]  hold_cnt;

    // decision terms
    logic        accept;
    logic        bad;
    logic        fc_drop;
    logic [2:0]  idx;
    logic [6:0]  code;
    logic        counted;
    logic        limited;
    prmirc_bkt_t cost;
    logic        over;
    logic        rl_fc;
    logic        drop;
    logic        push;
    logic        congested;
    prmirc_fwd_s push_data;
    logic        buf_ready;
    prmirc_lmode_e lmode;

    // field views
    logic bp_en;
    logic pass_all;
    logic port_based;
    logic pps_mode;
    logic rate_fc;
    logic ifg_en;
    logic pre_en;
    logic txfc_en;

    assign bp_en      = mac1[`PRMIRC_MAC1_BP];
    assign pass_all   = mac1[`PRMIRC_MAC1_PASS];
    assign port_based = rate[`PRMIRC_RATE_PORT];
    assign pps_mode   = rate[`PRMIRC_RATE_PPS];
    assign rate_fc    = rate[`PRMIRC_RATE_FC];
    assign ifg_en     = rate[`PRMIRC_RATE_IFG];
    assign pre_en     = rate[`PRMIRC_RATE_PRE];
    assign txfc_en    = ownctl[`PRMIRC_OWN_TXFC];
    assign lmode      = prmirc_lmode_e'(
        rate[`PRMIRC_RATE_MHI:`PRMIRC_RATE_MLO]);

    // saturating add keeps a long idle from wrapping a bucket
    function automatic prmirc_bkt_t sat_add(
        input prmirc_bkt_t a,
        input prmirc_bkt_t b
    );
        logic [`PRMIRC_BKT_W:0] s;
        s = {1'b0, a} + {1'b0, b};
        if (s > {1'b0, `PRMIRC_BKT_MAX}) begin
            return `PRMIRC_BKT_MAX;
        end
        return s[`PRMIRC_BKT_W-1:0];
    endfunction

    // register writes; reserved read-only bits are masked off
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mac1   <= `PRMIRC_REG_RST;
            rate   <= `PRMIRC_REG_RST;
            ownctl <= `PRMIRC_REG_RST;
        end else if (reg_wr) begin
            if (reg_addr == `PRMIRC_A_MAC1) begin
                mac1 <= reg_wdata & `PRMIRC_MAC1_WMASK;
            end
            if (reg_addr == `PRMIRC_A_RATE) begin
                rate <= reg_wdata & `PRMIRC_RATE_WMASK;
            end
            if (reg_addr == `PRMIRC_A_OWNCTL) begin
                ownctl <= {7'h00, reg_wdata[`PRMIRC_OWN_TXFC]};
            end
        end
    end

    // limits are staged per priority, all go live on the last one
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 8; i++) begin
                stage[i]   <= 7'h00;
                lim_act[i] <= 7'h00;
            end
        end else if (reg_wr && reg_addr[7:3] == 5'(`PRMIRC_A_PRIO0 >> 3)) begin
            stage[reg_addr[2:0]] <= reg_wdata[6:0];
            if (reg_addr == `PRMIRC_A_PRIO7) begin
                for (int i = 0; i < 7; i++) begin
                    lim_act[i] <= stage[i];
                end
                lim_act[7] <= reg_wdata[6:0];
            end
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (!reg_rd) begin
            reg_rdata <= 8'h00;
        end else if (reg_addr[7:3] == 5'(`PRMIRC_A_PRIO0 >> 3)) begin
            reg_rdata <= {1'b0, stage[reg_addr[2:0]]};
        end else begin
            unique case (reg_addr)
                `PRMIRC_A_MAC1:   reg_rdata <= mac1;
                `PRMIRC_A_RATE:   reg_rdata <= rate;
                `PRMIRC_A_OWNCTL: reg_rdata <= ownctl;
                `PRMIRC_A_STAT:   reg_rdata <= {4'h0, half_duplex,
                                    (hold_cnt != 7'h00), bp_assert,
                                    pause_req};
                `PRMIRC_A_DROPS:  reg_rdata <= drops;
                default:          reg_rdata <= 8'h00;
            endcase
        end
    end

    // frame classification at the descriptor port
    assign accept  = in_valid && in_ready;
    assign bad     = in_desc.crc_err ||
                     in_desc.len > `PRMIRC_MAX_LEN ||
                     in_desc.len < `PRMIRC_MIN_LEN;
    assign fc_drop = in_desc.fc_frame && fc_filter_en;
    assign idx     = port_based ? 3'h0 : in_desc.prio;
    assign code    = lim_act[idx];

    // which frames count against the limit
    always_comb begin
        unique case (lmode)
            LM_ALL: counted = 1'b1;
            LM_BMF: counted = in_desc.bcast || in_desc.mcast ||
                              in_desc.flood;
            LM_BM:  counted = in_desc.bcast || in_desc.mcast;
            LM_BC:  counted = in_desc.bcast;
        endcase
    end

    // code zero means the full line rate, so no limit at all
    assign limited = counted && code != 7'h00;

    // cost of one frame in packets or in bytes
    always_comb begin
        if (pps_mode) begin
            cost = prmirc_bkt_t'(1);
        end else begin
            cost = prmirc_bkt_t'(in_desc.len);
            if (ifg_en) begin
                cost = cost + `PRMIRC_IFG_BYTES;
            end
            if (pre_en) begin
                cost = cost + `PRMIRC_PRE_BYTES;
            end
        end
    end

    assign over  = limited && bkt[idx] < cost;
    // rate flow control needs both port and partner permission
    assign rl_fc = rate_fc && txfc_en && fc_adv;
    assign drop  = fc_drop ||
                   (bad && !pass_all) ||
                   (over && !rl_fc);
    assign push  = accept && !drop;

    // bad frames that survive are marked for mirror ports only
    always_comb begin
        push_data             = '0;
        push_data.desc        = in_desc;
        push_data.mirror_only = bad;
        push_data.over_rate   = over;
    end

    // refill tick; the period sets the meaning of one code step
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            refill_cnt <= 7'h00;
            tick       <= 1'b0;
        end else if (refill_cnt == 7'(REFILL_CYC - 1)) begin
            refill_cnt <= 7'h00;
            tick       <= 1'b1;
        end else begin
            refill_cnt <= refill_cnt + 7'h01;
            tick       <= 1'b0;
        end
    end

    // debit on the frame forwarded, credit on the tick
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            next_bkt[i] = bkt[i];
            if (push && limited && idx == 3'(i)) begin
                // frames let through under flow control empty it
                next_bkt[i] = over ? '0 : bkt[i] - cost;
            end
            if (tick) begin
                next_bkt[i] = sat_add(next_bkt[i], pps_mode ?
                    prmirc_bkt_t'(lim_act[i]) :
                    prmirc_bkt_t'(lim_act[i] * `PRMIRC_BYTE_CREDIT));
            end
        end
    end

    // token buckets, full after reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 8; i++) begin
                bkt[i] <= `PRMIRC_BKT_MAX;
            end
        end else begin
            for (int i = 0; i < 8; i++) begin
                bkt[i] <= next_bkt[i];
            end
        end
    end

    // hold flow control a while after each rate overrun under rate flow control
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hold_cnt <= 7'h00;
        end else if (accept && over && rl_fc) begin
            hold_cnt <= 7'(HOLD_CYC);
        end else if (hold_cnt != 7'h00) begin
            hold_cnt <= hold_cnt - 7'h01;
        end
    end

    // a full buffer also asks the partner to slow down
    assign congested = hold_cnt != 7'h00 || !buf_ready;

    // pick the mechanism from the duplex of the link
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bp_assert <= 1'b0;
            pause_req <= 1'b0;
        end else begin
            bp_assert <= half_duplex && bp_en && congested;
            pause_req <= !half_duplex && txfc_en && fc_adv &&
                         congested;
        end
    end

    // dropped frame count, sticks at the top; a write clears it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            drops <= 8'h00;
        end else if (accept && drop) begin
            // a drop in the clearing cycle still counts
            if (reg_wr && reg_addr == `PRMIRC_A_DROPS) begin
                drops <= 8'h01;
            end else if (drops != 8'hff) begin
                drops <= drops + 8'h01;
            end
        end else if (reg_wr && reg_addr == `PRMIRC_A_DROPS) begin
            drops <= 8'h00;
        end
    end

    // a stalled fabric loses no frame
    prmirc_buf2 u_buf (
        .clk     (clk),
        .rst     (rst),
        .s_valid (in_valid && !drop),
        .s_data  (push_data),
        .s_ready (buf_ready),
        .m_valid (out_valid),
        .m_data  (out_data),
        .m_ready (out_ready)
    );

    // dropped frames also wait on the buffer before they are taken
    assign in_ready = buf_ready;

    // back pressure follows its enable and the duplex
    bp_gate_a: assert property (
        @(posedge clk) disable iff (rst)
        bp_assert |-> $past(bp_en) && $past(half_duplex))
        else $error("back pressure without enable in half duplex");

    // no back pressure in full duplex
    bp_half_a: assert property (
        @(posedge clk) disable iff (rst)
        !half_duplex ##1 !half_duplex |-> !bp_assert)
        else $error("back pressure raised in full duplex");

    // pause only in full duplex and with transmit flow control
    pause_gate_a: assert property (
        @(posedge clk) disable iff (rst)
        pause_req |-> $past(!half_duplex) && $past(txfc_en))
        else $error("pause without full duplex or enable");

    // bad frames are dropped unless pass-all is set
    bad_drop_a: assert property (
        @(posedge clk) disable iff (rst)
        accept && bad && !pass_all |-> !push)
        else $error("bad frame forwarded with pass-all clear");

    // a forwarded bad frame reaches the output marked mirror only
    mirror_mark_a: assert property (
        @(posedge clk) disable iff (rst)
        push && bad && out_ready && !out_valid |=>
        out_valid && out_data.mirror_only)
        else $error("bad frame not marked mirror only");

    // filtered flow control frames go even with pass-all set
    fc_filter_a: assert property (
        @(posedge clk) disable iff (rst)
        accept && in_desc.fc_frame && fc_filter_en |-> !push)
        else $error("filtered flow control frame forwarded");

    // staging writes leave live limits alone
    stage_hold_a: assert property (
        @(posedge clk) disable iff (rst)
        reg_wr && reg_addr == `PRMIRC_A_PRIO0 |=>
        lim_act[0] == $past(lim_act[0]))
        else $error("limit took effect before commit");

    // the priority 7 write commits every staged limit
    commit_a: assert property (
        @(posedge clk) disable iff (rst)
        reg_wr && reg_addr == `PRMIRC_A_PRIO7 |=>
        lim_act[0] == stage[0] && lim_act[7] == $past(reg_wdata[6:0]))
        else $error("staged limits not committed");

    // excess frames without rate flow control are discarded
    over_drop_a: assert property (
        @(posedge clk) disable iff (rst)
        accept && over && !rl_fc |-> !push)
        else $error("excess frame forwarded");

    // an overrun under rate flow control starts the full hold
    hold_start_a: assert property (
        @(posedge clk) disable iff (rst)
        accept && over && rl_fc |=> hold_cnt == 7'(HOLD_CYC))
        else $error("flow control hold not started");

    // without partner permission a rate overrun never holds
    rlfc_need_a: assert property (
        @(posedge clk) disable iff (rst)
        hold_cnt == 7'h00 && !fc_adv |=> hold_cnt == 7'h00)
        else $error("rate flow control without permission");
endmodule

// >>> verilog/prmirc_cfg.svh
// constants of the port mac ingress rate control block
// Notes on behaviour
// - Back pressure is applied on the port only while its enable is set.
// - Back pressure acts only in half duplex, never in full duplex.
// - Full duplex uses pause flow control under its own enable.
// - With pass-all clear, crc, oversize and undersize frames are dropped.
// - With pass-all set, bad frames go out marked for mirroring only.
// - Flow control frame filtering ignores pass-all; a global input rules.
// - Basis bit set limits per port, clear limits per frame priority.
// - Packet mode bit set counts packets, clear counts bytes.
// - Rate flow control bit set asserts flow control when rate exceeded.
// - Rate flow control needs port flow control and partner advert.
// - Limit mode picks counted frames: all, b+m+flood, b+m, b only.
// - Count ifg bit adds twelve bytes per frame to the byte cost.
// - Count preamble bit adds eight bytes per frame to the byte cost.
// - Preamble counting is ignored while packet mode is on.
// - Transmit flow control enable permits or forbids sending flow control.
// - Priority limits are staged and all commit on the priority 7 write.
`ifndef PRMIRC_CFG_SVH
`define PRMIRC_CFG_SVH
`define PRMIRC_A_MAC1      8'h01
`define PRMIRC_A_RATE      8'h03
`define PRMIRC_A_PRIO0     8'h10
`define PRMIRC_A_PRIO7     8'h17
`define PRMIRC_A_OWNCTL    8'h20
`define PRMIRC_A_STAT      8'h21
`define PRMIRC_A_DROPS     8'h22
`define PRMIRC_MAC1_BP     3
`define PRMIRC_MAC1_PASS   0
`define PRMIRC_MAC1_WMASK  8'hbf
`define PRMIRC_RATE_PORT   6
`define PRMIRC_RATE_PPS    5
`define PRMIRC_RATE_FC     4
`define PRMIRC_RATE_MHI    3
`define PRMIRC_RATE_MLO    2
`define PRMIRC_RATE_IFG    1
`define PRMIRC_RATE_PRE    0
`define PRMIRC_RATE_WMASK  8'h7f
`define PRMIRC_PRIO_WMASK  8'h7f
`define PRMIRC_OWN_TXFC    0
`define PRMIRC_REG_RST     8'h00
`define PRMIRC_IFG_BYTES   18'd12
`define PRMIRC_PRE_BYTES   18'd8
`define PRMIRC_MIN_LEN     11'd64
`define PRMIRC_MAX_LEN     11'd1522
`define PRMIRC_BKT_W       18
`define PRMIRC_BKT_MAX     18'h0ffff
`define PRMIRC_BYTE_CREDIT 18'd125
`define PRMIRC_CLK_NS      8
`define PRMIRC_REFILL_NS   1000
`define PRMIRC_REFILL_CYC  (`PRMIRC_REFILL_NS / `PRMIRC_CLK_NS)
`define PRMIRC_HOLD_NS     512
`define PRMIRC_HOLD_CYC    (`PRMIRC_HOLD_NS / `PRMIRC_CLK_NS)
`endif

// >>> verilog/prmirc_pkg.sv
// types of the port mac ingress rate control block
`include "prmirc_cfg.svh"
package prmirc_pkg;
    // one received frame as seen at its end
    typedef struct packed {
        logic [10:0] len;
        logic [2:0]  prio;
        logic        bcast;
        logic        mcast;
        logic        flood;
        logic        crc_err;
        logic        fc_frame;
    } prmirc_desc_s;
    // a frame handed on to the fabric
    typedef struct packed {
        prmirc_desc_s desc;
        logic         mirror_only;
        logic         over_rate;
    } prmirc_fwd_s;
    typedef enum logic [1:0] {
        LM_ALL = 2'b00,
        LM_BMF = 2'b01,
        LM_BM  = 2'b10,
        LM_BC  = 2'b11
    } prmirc_lmode_e;
    typedef logic [`PRMIRC_BKT_W-1:0] prmirc_bkt_t;
endpackage

// >>> verilog/prmirc_buf2.sv
// two-entry buffer with registered outputs on both sides
module prmirc_buf2
    import prmirc_pkg::*;
(
    input  logic        clk,     // core clock
    input  logic        rst,     // async reset
    input  logic        s_valid, // write side valid
    input  prmirc_fwd_s s_data,  // write side word
    output logic        s_ready, // write side ready
    output logic        m_valid, // read side valid
    output prmirc_fwd_s m_data,  // read side word
    input  logic        m_ready  // read side ready
);
    logic        spare_v;
    prmirc_fwd_s spare;
    logic        take;
    logic        head_free;

    assign take      = s_valid && s_ready;
    assign head_free = !m_valid || m_ready;

    // head feeds the reader, spare catches the word of a stall
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            m_valid <= 1'b0;
            m_data  <= '0;
            spare_v <= 1'b0;
            spare   <= '0;
            s_ready <= 1'b1;
        end else if (head_free) begin
            m_valid <= spare_v || take;
            spare_v <= 1'b0;
            s_ready <= 1'b1;
            if (spare_v) begin
                m_data <= spare;
            end else if (take) begin
                m_data <= s_data;
            end
        end else begin
            if (take) begin
                spare   <= s_data;
                spare_v <= 1'b1;
            end
            s_ready <= !(spare_v || take);
        end
    end
endmodule

// >>> test/prmirc_link_partner.sv
// link partner model: frame descriptors, duplex and advert state
module prmirc_link_partner
    import prmirc_pkg::*;
(
    input  logic         clk,         // core clock
    input  logic         in_ready,    // descriptor taken
    output logic         in_valid,    // descriptor valid
    output prmirc_desc_s in_desc,     // descriptor
    output logic         half_duplex, // link runs half duplex
    output logic         fc_adv       // flow control agreed
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle levels at time zero
    initial begin
        in_valid    = 1'b0;
        in_desc     = '0;
        half_duplex = 1'b0;
        fc_adv      = 1'b0;
    end
    // duplex and advert only move after an edge
    task automatic link(input logic half, input logic adv);
        half_duplex <= half;
        fc_adv      <= adv;
    endtask
    // n copies of one descriptor; valid held so back to back frames
    // never see a one-cycle gap
    task automatic burst(input prmirc_desc_s d, input int n);
        int k;
        @(posedge clk);
        in_valid <= 1'b1;
        in_desc  <= d;
        repeat (n) begin
            k = 0;
            do begin
                @(posedge clk);
                k++;
            end while (in_ready !== 1'b1 && k < 500);
        end
        // released bus shows the inverse, never a stale copy
        in_valid <= 1'b0;
        in_desc  <= ~d;
    endtask
endmodule

// >>> test/prmirc_top_tb.sv
// self-checking bench for the port mac ingress rate control block
module prmirc_top_tb
    import prmirc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int N = 68; // frames per rate burst, above every byte-mode limit
    typedef struct {
        logic [7:0]  mac1;
        logic        filt;
        logic [10:0] len;
        logic        crc;
        logic        fc;
        logic        fwd;
        logic        mir;
    } prmirc_frow_s;
    typedef struct {
        logic [7:0] rate;
        logic [2:0] prio;
        logic [2:0] cls;
        logic       commit;
        logic       txfc;
        logic       adv;
    } prmirc_rrow_s;
    logic         clk = 1'b0;
    logic         rst, reg_wr, reg_rd, fc_filter_en, out_ready, pause_seen;
    logic [7:0]   reg_addr, reg_wdata, reg_rdata;
    logic         in_valid, in_ready, out_valid, half_duplex, fc_adv;
    logic         bp_assert, pause_req, cnt, lim, rlfc;
    logic [1:0]   m;
    prmirc_desc_s in_desc, d;
    prmirc_fwd_s  out_data;
    prmirc_fwd_s  got[$];
    prmirc_rrow_s r;
    int           mismatches = 0;
    int           n_tests = 0;
    int           drops, exp, pass, cost;
    logic [7:0]   ra [4] = '{8'h01, 8'h03, 8'h11, 8'h20};
    logic [7:0]   rm [4] = '{8'hbf, 8'h7f, 8'h7f, 8'h01};
    // mac1, filter, len, crc, fc frame, forwarded, mirror only
    prmirc_frow_s frows [11] = '{
        '{0, 0, 100, 0, 0, 1, 0}, '{0, 0, 100, 1, 0, 0, 0},
        '{0, 0, 1523, 0, 0, 0, 0}, '{0, 0, 63, 0, 0, 0, 0},
        '{0, 0, 1522, 0, 0, 1, 0}, '{0, 0, 64, 0, 0, 1, 0},
        '{1, 0, 100, 1, 0, 1, 1}, '{1, 0, 1523, 0, 0, 1, 1},
        '{1, 1, 100, 0, 1, 0, 0}, '{0, 0, 100, 0, 1, 1, 0},
        '{8, 0, 63, 0, 0, 0, 0}};
    // rate, prio, class {b,m,f}, commit, tx flow control, advert
    prmirc_rrow_s rrows [16] = '{
        '{'h40, 3, 0, 1, 0, 0}, '{'h00, 3, 0, 1, 0, 0},
        '{'h00, 0, 0, 1, 0, 0}, '{'h42, 3, 0, 1, 0, 0},
        '{'h41, 3, 0, 1, 0, 0}, '{'h61, 3, 0, 1, 0, 0},
        '{'h44, 3, 1, 1, 0, 0}, '{'h48, 3, 1, 1, 0, 0},
        '{'h48, 3, 2, 1, 0, 0}, '{'h4c, 3, 2, 1, 0, 0},
        '{'h4c, 3, 4, 1, 0, 0}, '{'h40, 3, 0, 0, 0, 0},
        '{'h50, 3, 0, 1, 1, 1}, '{'h50, 3, 0, 1, 1, 0},
        '{'h50, 3, 0, 1, 0, 1}, '{'h40, 3, 0, 1, 1, 1}};

    prmirc_top dut (.clk(clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .half_duplex(half_duplex), .fc_adv(fc_adv),
        .fc_filter_en(fc_filter_en), .in_valid(in_valid),
        .in_desc(in_desc), .in_ready(in_ready), .out_valid(out_valid),
        .out_data(out_data), .out_ready(out_ready),
        .bp_assert(bp_assert), .pause_req(pause_req));
    prmirc_link_partner lp (.clk(clk), .in_ready(in_ready),
        .in_valid(in_valid), .in_desc(in_desc),
        .half_duplex(half_duplex), .fc_adv(fc_adv));

    // 125 mhz core clock
    always #4 clk = ~clk;
    // fabric side: keep every accepted frame and any pause request;
    // the only driver of pause_seen, so reset clears it here
    always @(posedge clk) begin
        if (out_valid === 1'b1 && out_ready === 1'b1) begin
            got.push_back(out_data);
        end
        if (rst === 1'b1) begin
            pause_seen <= 1'b0;
        end else if (pause_req === 1'b1) begin
            pause_seen <= 1'b1;
        end
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        chk(reg_rdata, e);
    endtask
    task automatic do_reset;
        @(posedge clk);
        rst <= 1'b1;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        got.delete();
    endtask
    function automatic prmirc_desc_s mk(input logic [10:0] len,
        input logic [2:0] prio, input logic [2:0] cls, input logic crc,
        input logic fc);
        return {len, prio, cls, crc, fc};
    endfunction
    task automatic results;
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // watchdog, well past the few thousand cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        $display("watchdog expired");
        results();
    end

    initial begin
        rst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        fc_filter_en = 1'b0;
        out_ready = 1'b1;
        do_reset();
        // reset values, writable bits, unmapped place
        foreach (ra[i]) rd(ra[i], 8'h00);
        foreach (ra[i]) begin
            wr(ra[i], 8'hff);
            rd(ra[i], rm[i]);
        end
        wr(8'h05, 8'hff);
        rd(8'h05, 8'h00);
        $display("register test done");
        do_reset();
        // frame filtering rows, buckets unlimited
        drops = 0;
        foreach (frows[i]) begin
            fc_filter_en <= frows[i].filt;
            wr(8'h01, frows[i].mac1);
            d = mk(frows[i].len, 0, 0, frows[i].crc, frows[i].fc);
            lp.burst(d, 1);
            repeat (5) @(posedge clk);
            chk(got.size(), frows[i].fwd);
            if (frows[i].fwd) chk(got[0], {d, frows[i].mir, 1'b0});
            else drops++;
            got.delete();
        end
        rd(8'h22, drops[7:0]);
        $display("filter test done");
        // stall the fabric until the buffer refuses, then sweep settings
        out_ready <= 1'b0;
        lp.burst(mk(100, 1, 0, 0, 0), 2);
        @(posedge clk);
        chk(in_ready, 1'b0);
        for (int i = 0; i < 16; i++) begin
            wr(8'h01, {4'h0, i[2], 3'h0});
            wr(8'h20, {7'h0, i[1]});
            lp.link(i[3], i[0]);
            repeat (3) @(posedge clk);
            m = {i[3] & i[2], !i[3] & i[1] & i[0]};
            chk({bp_assert, pause_req}, m);
        end
        out_ready <= 1'b1;
        repeat (6) @(posedge clk);
        chk(got.size(), 2);
        chk(bp_assert, 1'b0);
        $display("back pressure test done");
        // rate rows: reset refills every bucket before each burst
        foreach (rrows[i]) begin
            r = rrows[i];
            do_reset();
            lp.link(1'b0, r.adv);
            wr(8'h10, 8'h01);
            if (r.commit) wr(8'h17, 8'h00);
            wr(8'h03, r.rate);
            wr(8'h20, {7'h0, r.txfc});
            lp.burst(mk(1020, r.prio, r.cls, 0, 0), N);
            repeat (30) @(posedge clk);
            m = r.rate[3:2];
            cnt = m == 0 || (m == 1 && r.cls != 0) ||
                  (m == 2 && r.cls[2:1] != 0) || (m == 3 && r.cls[2]);
            lim = r.commit && cnt && (r.rate[6] || r.prio == 0);
            cost = r.rate[5] ? 1 :
                   1020 + (r.rate[1] ? 12 : 0) + (r.rate[0] ? 8 : 0);
            exp = lim ? 65535 / cost : N;
            if (exp > N) exp = N;
            rlfc = r.rate[4] && r.txfc && r.adv;
            pass = 0;
            foreach (got[j]) pass += !got[j].over_rate;
            chk(pass, exp);
            chk(got.size(), rlfc ? N : exp);
            chk(pause_seen, rlfc && exp < N);
        end
        $display("rate test done");
        results();
    end
endmodule
